// [hdl/rs_out_consts.vh]
/*
 * constants for the decoder output and status block: register
 * offsets, register reset values and status word element positions.
 * assumes inclusion by bare name from the design file.
 */
`ifndef RS_OUT_CONSTS_VH
`define RS_OUT_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define RSO_ADDR_W       4
`define RSO_OFS_CTRL     4'h0
`define RSO_OFS_STATUS   4'h4
`define RSO_OFS_LEVEL    4'h8

// ****************************************
// register fields and reset values
// ****************************************
`define RSO_CTRL_CHKOUT  0
`define RSO_CTRL_RST     1'b0
`define RSO_ST_INVALID   0
`define RSO_ST_MISSING   1
`define RSO_ST_UNEXP     2

// ****************************************
// status word element positions
// ****************************************
`define RSO_STAT_FAIL    0
`define RSO_STAT_FOUND   1
`define RSO_STAT_ERRCNT  2

`endif

// [hdl/rs_decoder_output_status.v]
/*
 * output side of the error-correcting block decoder: corrected-symbol
 * stream with raw copy, data/check flag and marker sideband, the
 * per-block status stream, end-of-block marking, input framing events
 * and control range check, plus a small apb register set.
 * assumes the decoding core on the same clock delivers symbols block
 * by block, channel after channel, with that block's fail flag,
 * corrected count, n and k valid alongside the block's first symbol.
 */
// Overview of operation
// R01: each output data field is zero-padded to a multiple of eight bits.
// R02: corrected field carries decoded symbols, as wide as the input symbol.
// R03: output delay may vary with block length changes or output stalls.
// R04: raw input symbol leaves with the same delay, symbol wide.
// R05: data/check flag high on message symbols, low on last n-k.
// R06: output marker equals input marker, same delay, same width.
// R07: output last on kth or nth symbol, last channel only.
// R08: one status word per block per channel after its last symbol.
// R09: consumer takes status in time, else input stalls; tie ready high.
// R10: status and data channels handshake independently of each other.
// R11: status packed lsb first fail,found,count,erasures,bit counts; padded.
// R12: fail set when errors exceed capacity; other elements then undefined.
// R13: corrected symbols of a failed block are undefined.
// R14: error-found high when any error, erasure or puncture was seen.
// R15: corrected count width fits n-k.
// R16: erasure count present with erasure support, width fits n.
// R17: count bits received one corrected to zero, width fits (n-k)*w.
// R18: equally wide count of bits received zero corrected to one.
// R19: status last only in multichannel mode, on the last channel.
// R20: missing-end event when input last is absent on final symbol.
// R21: unexpected-end event when input last comes early; same timing.
// R22: sticky invalid-control event on out-of-range length or checks.
// R23: erasure count is symbols flagged erased in the block output.
// R24: status words of a block leave in ascending channel order.
// R25: status word held stable until the consumer accepts it.

`timescale 1ns/1ps
`include "rs_out_consts.vh"

module rs_decoder_output_status #(
  parameter SYM_W      = 8,
  parameter N_MAX      = 255,
  parameter K_MIN      = 239,
  parameter N_MIN      = 3,
  parameter R_MIN      = 2,
  parameter CHANNELS   = 1,
  parameter MARK_W     = 1,
  parameter STAT_DEPTH = 4,
  // derived port widths; leave at their defaults
  parameter OUT_W      = 2 * (((SYM_W + 7) / 8) * 8) + 8,
  parameter STAT_W     = ((2 + $clog2(N_MAX - K_MIN + 1) +
                          $clog2(N_MAX + 1) +
                          2 * $clog2((N_MAX - K_MIN) * SYM_W + 1) +
                          7) / 8) * 8
) (
  // clock, reset, enable
  input  wire                   CLK_SYS_I,
  input  wire                   SRST_I,
  input  wire                   CE_I,
  // symbols from the decoding core
  input  wire                   SYM_VALID_I,
  output wire                   SYM_READY_O,
  input  wire [SYM_W-1:0]       SYM_CORR_I,
  input  wire [SYM_W-1:0]       SYM_RAW_I,
  input  wire [MARK_W-1:0]      SYM_MARK_I,
  input  wire                   SYM_ERASED_I,
  input  wire                   BLK_FAIL_I,
  input  wire [15:0]            BLK_ERRCNT_I,
  input  wire [15:0]            BLK_N_I,
  input  wire [15:0]            BLK_K_I,
  // observed input and control handshakes
  input  wire                   IN_TVALID_I,
  input  wire                   IN_TREADY_I,
  input  wire                   IN_TLAST_I,
  input  wire                   CTRL_TVALID_I,
  input  wire                   CTRL_TREADY_I,
  input  wire [15:0]            CTRL_N_I,
  input  wire [15:0]            CTRL_R_I,
  // corrected output stream
  output reg                    M_AXIS_OUTPUT_TVALID_O,
  input  wire                   M_AXIS_OUTPUT_TREADY_I,
  output reg  [OUT_W-1:0]       M_AXIS_OUTPUT_TDATA_O,
  output reg  [MARK_W-1:0]      M_AXIS_OUTPUT_TUSER_O,
  output reg                    M_AXIS_OUTPUT_TLAST_O,
  // status stream
  output wire                   M_AXIS_STAT_TVALID_O,
  input  wire                   M_AXIS_STAT_TREADY_I,
  output wire [STAT_W-1:0]      M_AXIS_STAT_TDATA_O,
  output wire                   M_AXIS_STAT_TLAST_O,
  // events
  output reg                    EVENT_TLAST_MISSING_O,
  output reg                    EVENT_TLAST_UNEXPECTED_O,
  output reg                    EVENT_CTRL_INVALID_O,
  // apb slave
  input  wire                   PSEL_I,
  input  wire                   PENABLE_I,
  input  wire                   PWRITE_I,
  input  wire [`RSO_ADDR_W-1:0] PADDR_I,
  input  wire [31:0]            PWDATA_I,
  output reg  [31:0]            PRDATA_O,
  output wire                   PREADY_O,
  output wire                   PSLVERR_O
);

  // ****************************************
  // widths
  // ****************************************
  function integer bits_for;
    input integer v;
    integer t;
    begin
      bits_for = 1;
      t = v;
      while (t > 1) begin
        t = t / 2;
        bits_for = bits_for + 1;
      end
    end
  endfunction

  localparam SYM_P  = ((SYM_W + 7) / 8) * 8;        // [R01]
  localparam EW     = bits_for(N_MAX - K_MIN);      // [R15]
  localparam AW     = bits_for(N_MAX);              // [R16]
  localparam BW     = bits_for((N_MAX - K_MIN) * SYM_W); // [R17]
  localparam ST_RAW = 2 + EW + AW + 2 * BW;
  localparam PW     = bits_for(N_MAX);
  localparam CW     = bits_for(CHANNELS);
  localparam TW     = PW + CW;
  localparam LW     = bits_for(STAT_DEPTH);
  localparam IW     = bits_for(STAT_DEPTH - 1);
  localparam R_MAX  = N_MAX - K_MIN;

  function [BW-1:0] ones;
    input [SYM_W-1:0] v;
    integer i;
    begin
      ones = {BW{1'b0}};
      for (i = 0; i < SYM_W; i = i + 1)
        ones = ones + {{(BW-1){1'b0}}, v[i]};
    end
  endfunction

  // ****************************************
  // output side block tracking
  // ****************************************
  reg  [PW-1:0]     pos;
  reg  [CW-1:0]     chan;
  reg  [15:0]       blk_n;
  reg  [15:0]       blk_k;
  reg               fail;
  reg  [EW-1:0]     ecnt;
  reg  [AW-1:0]     era;
  reg  [BW-1:0]     to0;
  reg  [BW-1:0]     to1;
  reg               check_out;
  reg  [LW-1:0]     st_cnt;

  wire              first   = (pos == {PW{1'b0}});
  wire [15:0]       n_cur   = first ? BLK_N_I : blk_n;
  wire [15:0]       k_cur   = first ? BLK_K_I : blk_k;
  wire [15:0]       pos16   = {{(16-PW){1'b0}}, pos};
  wire              is_data = (pos16 < k_cur);
  wire              is_last = (pos16 == n_cur - 16'h0001);
  wire              last_ch = (chan == CHANNELS - 1);
  wire              st_full = (st_cnt == STAT_DEPTH);
  wire              slot    = !M_AXIS_OUTPUT_TVALID_O ||
                              M_AXIS_OUTPUT_TREADY_I;
  // a full status queue stalls the core and so the input [R09]
  assign SYM_READY_O = CE_I && slot && !st_full;
  wire              sym_fire = SYM_VALID_I && SYM_READY_O;
  wire              emit     = is_data || check_out;

  wire [BW-1:0] d0 = ones(SYM_RAW_I & ~SYM_CORR_I);   // [R17]
  wire [BW-1:0] d1 = ones(~SYM_RAW_I & SYM_CORR_I);   // [R18]
  wire [BW-1:0] n_to0 = (first ? {BW{1'b0}} : to0) + d0;
  wire [BW-1:0] n_to1 = (first ? {BW{1'b0}} : to1) + d1;
  wire [AW-1:0] n_era = (first ? {AW{1'b0}} : era) +
                        {{(AW-1){1'b0}}, SYM_ERASED_I}; // [R23]
  wire          n_fail = first ? BLK_FAIL_I : fail;    // [R12]
  wire [EW-1:0] n_ecnt = first ? BLK_ERRCNT_I[EW-1:0] : ecnt;
  // found covers failure, corrections and erasures alike
  wire          n_found = n_fail || (n_ecnt != {EW{1'b0}}) ||
                          (n_era != {AW{1'b0}});       // [R14]
  wire [ST_RAW-1:0] st_word = {n_to1, n_to0, n_era, n_ecnt,
                               n_found, n_fail};       // [R11]

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pos    <= {PW{1'b0}};
      chan   <= {CW{1'b0}};
      blk_n  <= 16'h0000;
      blk_k  <= 16'h0000;
      fail   <= 1'b0;
      ecnt   <= {EW{1'b0}};
      era    <= {AW{1'b0}};
      to0    <= {BW{1'b0}};
      to1    <= {BW{1'b0}};
    end else if (sym_fire) begin
      blk_n <= n_cur;
      blk_k <= k_cur;
      fail  <= n_fail;
      ecnt  <= n_ecnt;
      era   <= n_era;
      to0   <= n_to0;
      to1   <= n_to1;
      if (is_last) begin
        pos  <= {PW{1'b0}};
        chan <= last_ch ? {CW{1'b0}} : chan + {{(CW-1){1'b0}}, 1'b1};
      end else begin
        pos  <= pos + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // corrected output register
  // ****************************************
  // one stage only; latency shifts with stalls and block length [R03]
  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      M_AXIS_OUTPUT_TVALID_O <= 1'b0;
      M_AXIS_OUTPUT_TDATA_O  <= {OUT_W{1'b0}};
      M_AXIS_OUTPUT_TUSER_O  <= {MARK_W{1'b0}};
      M_AXIS_OUTPUT_TLAST_O  <= 1'b0;
    end else if (CE_I) begin
      if (sym_fire && emit) begin
        M_AXIS_OUTPUT_TVALID_O <= 1'b1;
        // failed blocks pass whatever the core produced [R13]
        M_AXIS_OUTPUT_TDATA_O <= {{7{1'b0}}, is_data,          // [R05]
          {(SYM_P-SYM_W){1'b0}}, SYM_RAW_I,                    // [R04]
          {(SYM_P-SYM_W){1'b0}}, SYM_CORR_I};                  // [R02]
        M_AXIS_OUTPUT_TUSER_O <= SYM_MARK_I;                   // [R06]
        M_AXIS_OUTPUT_TLAST_O <= last_ch &&
          (check_out ? is_last :
           (pos16 == k_cur - 16'h0001));                       // [R07]
      end else if (M_AXIS_OUTPUT_TREADY_I) begin
        M_AXIS_OUTPUT_TVALID_O <= 1'b0;
      end
    end
  end

  // ****************************************
  // status queue
  // ****************************************
  // filled in channel order as blocks finish, drained on its own [R10]
  reg  [STAT_W:0]   st_mem [0:STAT_DEPTH-1];
  reg  [IW-1:0]     st_wp;
  reg  [IW-1:0]     st_rp;
  wire              st_push = sym_fire && is_last;             // [R08]
  wire              st_pop  = M_AXIS_STAT_TVALID_O &&
                              M_AXIS_STAT_TREADY_I && CE_I;
  wire              st_tl   = (CHANNELS > 1) && last_ch;       // [R19]

  assign M_AXIS_STAT_TVALID_O = (st_cnt != {LW{1'b0}});
  // head entry stays put until taken [R25]
  assign M_AXIS_STAT_TDATA_O  = st_mem[st_rp][STAT_W-1:0];
  assign M_AXIS_STAT_TLAST_O  = M_AXIS_STAT_TVALID_O &&
                                st_mem[st_rp][STAT_W];

  always @(posedge CLK_SYS_I) begin
    if (st_push)
      st_mem[st_wp] <= {st_tl, {(STAT_W-ST_RAW){1'b0}}, st_word}; // [R24]
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      st_wp  <= {IW{1'b0}};
      st_rp  <= {IW{1'b0}};
      st_cnt <= {LW{1'b0}};
    end else if (CE_I) begin
      if (st_push)
        st_wp <= (st_wp == STAT_DEPTH - 1) ? {IW{1'b0}} :
                 st_wp + {{(IW-1){1'b0}}, 1'b1};
      if (st_pop)
        st_rp <= (st_rp == STAT_DEPTH - 1) ? {IW{1'b0}} :
                 st_rp + {{(IW-1){1'b0}}, 1'b1};
      if (st_push && !st_pop)
        st_cnt <= st_cnt + {{(LW-1){1'b0}}, 1'b1};
      else if (st_pop && !st_push)
        st_cnt <= st_cnt - {{(LW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // input framing and control checks
  // ****************************************
  reg  [15:0]       in_n;
  reg  [TW-1:0]     in_pos;
  wire              in_fire   = IN_TVALID_I && IN_TREADY_I;
  wire              ctrl_fire = CTRL_TVALID_I && CTRL_TREADY_I;
  wire [TW-1:0]     in_total  = in_n[TW-1:0] * CHANNELS[TW-1:0];
  wire              in_last   = (in_pos == in_total - {{(TW-1){1'b0}},1'b1});
  wire              ctrl_bad  = (CTRL_N_I > N_MAX) ||
                                (CTRL_N_I < N_MIN) ||
                                (CTRL_R_I > R_MAX) ||
                                (CTRL_R_I < R_MIN) ||
                                (CTRL_R_I >= CTRL_N_I);

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      in_n                     <= N_MAX[15:0];
      in_pos                   <= {TW{1'b0}};
      EVENT_TLAST_MISSING_O    <= 1'b0;
      EVENT_TLAST_UNEXPECTED_O <= 1'b0;
      EVENT_CTRL_INVALID_O     <= 1'b0;
    end else if (CE_I) begin
      // a bad value never becomes the running length
      if (ctrl_fire && !ctrl_bad)
        in_n <= CTRL_N_I;
      if (ctrl_fire && ctrl_bad)
        EVENT_CTRL_INVALID_O <= 1'b1;                          // [R22]
      if (in_fire) begin
        in_pos <= in_last ? {TW{1'b0}} :
                  in_pos + {{(TW-1){1'b0}}, 1'b1};
        // each pulse lasts until the next input sample [R20]
        EVENT_TLAST_MISSING_O    <= in_last && !IN_TLAST_I;   // [R20]
        EVENT_TLAST_UNEXPECTED_O <= !in_last && IN_TLAST_I;   // [R21]
      end
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  reg               seen_miss;
  reg               seen_unexp;
  wire              apb_wr  = PSEL_I && PENABLE_I && PWRITE_I && CE_I;
  wire              hit     = (PADDR_I == `RSO_OFS_CTRL) ||
                              (PADDR_I == `RSO_OFS_STATUS) ||
                              (PADDR_I == `RSO_OFS_LEVEL);
  wire              clr_ok  = apb_wr && (PADDR_I == `RSO_OFS_STATUS);
  reg  [31:0]       rd_mux;

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (PADDR_I)
      `RSO_OFS_CTRL:
        rd_mux[`RSO_CTRL_CHKOUT] = check_out;
      `RSO_OFS_STATUS: begin
        rd_mux[`RSO_ST_INVALID] = EVENT_CTRL_INVALID_O;
        rd_mux[`RSO_ST_MISSING] = seen_miss;
        rd_mux[`RSO_ST_UNEXP]   = seen_unexp;
      end
      `RSO_OFS_LEVEL:
        rd_mux[LW-1:0] = st_cnt;
      default:
        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      check_out  <= `RSO_CTRL_RST;
      seen_miss  <= 1'b0;
      seen_unexp <= 1'b0;
      PRDATA_O   <= 32'h0000_0000;
    end else if (CE_I) begin
      if (PSEL_I && !PENABLE_I)
        PRDATA_O <= rd_mux;
      if (apb_wr && (PADDR_I == `RSO_OFS_CTRL))
        check_out <= PWDATA_I[`RSO_CTRL_CHKOUT];
      // a new event outweighs a write-one clear in the same cycle
      if (EVENT_TLAST_MISSING_O)
        seen_miss <= 1'b1;
      else if (clr_ok && PWDATA_I[`RSO_ST_MISSING])
        seen_miss <= 1'b0;
      if (EVENT_TLAST_UNEXPECTED_O)
        seen_unexp <= 1'b1;
      else if (clr_ok && PWDATA_I[`RSO_ST_UNEXP])
        seen_unexp <= 1'b0;
    end
  end

endmodule

// [tb/rs_out_props.sv]
/* assertions on the output block's ports.
   assumes the default status element widths. */
`timescale 1ns/1ps
module rs_out_props #(
  parameter OUT_W  = 24,
  parameter STAT_W = 32,
  parameter MARK_W = 1
) (
  input wire logic              CLK_SYS_I,
  input wire logic              SRST_I,
  input wire logic              IN_TVALID_I,
  input wire logic              IN_TREADY_I,
  input wire logic              IN_TLAST_I,
  input wire logic              M_AXIS_OUTPUT_TVALID_O,
  input wire logic              M_AXIS_OUTPUT_TREADY_I,
  input wire logic [OUT_W-1:0]  M_AXIS_OUTPUT_TDATA_O,
  input wire logic [MARK_W-1:0] M_AXIS_OUTPUT_TUSER_O,
  input wire logic              M_AXIS_OUTPUT_TLAST_O,
  input wire logic              M_AXIS_STAT_TVALID_O,
  input wire logic              M_AXIS_STAT_TREADY_I,
  input wire logic [STAT_W-1:0] M_AXIS_STAT_TDATA_O,
  input wire logic              EVENT_TLAST_MISSING_O,
  input wire logic              EVENT_TLAST_UNEXPECTED_O,
  input wire logic              EVENT_CTRL_INVALID_O
);
  wire in_hs = IN_TVALID_I & IN_TREADY_I;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  a_out_hold: assert property (
    M_AXIS_OUTPUT_TVALID_O && !M_AXIS_OUTPUT_TREADY_I |=> M_AXIS_OUTPUT_TVALID_O
    && $stable({M_AXIS_OUTPUT_TDATA_O, M_AXIS_OUTPUT_TUSER_O}))
    else $error("output beat changed before accept");
  a_out_pad: assert property (
    M_AXIS_OUTPUT_TVALID_O |-> M_AXIS_OUTPUT_TDATA_O[OUT_W-1:OUT_W-7] == 7'h0)
    else $error("output padding not zero");
  a_stat_hold: assert property (
    M_AXIS_STAT_TVALID_O && !M_AXIS_STAT_TREADY_I |=> M_AXIS_STAT_TVALID_O
    && $stable(M_AXIS_STAT_TDATA_O)) else $error("status changed before accept");
  a_stat_pad: assert property (
    M_AXIS_STAT_TVALID_O |-> M_AXIS_STAT_TDATA_O[STAT_W-1] == 1'b0)
    else $error("status padding not zero");
  a_found_count: assert property (
    M_AXIS_STAT_TVALID_O && !M_AXIS_STAT_TDATA_O[0]
    && M_AXIS_STAT_TDATA_O[6:2] != 5'h0 |-> M_AXIS_STAT_TDATA_O[1])
    else $error("found flag low with nonzero count");
  a_ctrl_sticky: assert property (
    EVENT_CTRL_INVALID_O |=> EVENT_CTRL_INVALID_O)
    else $error("invalid control event dropped");
  a_miss_cause: assert property (
    $rose(EVENT_TLAST_MISSING_O) |-> $past(in_hs && !IN_TLAST_I))
    else $error("missing end raised without sample");
  a_miss_clear: assert property (
    EVENT_TLAST_MISSING_O && in_hs |=> !EVENT_TLAST_MISSING_O)
    else $error("missing end held past next sample");
  a_unexp_cause: assert property (
    $rose(EVENT_TLAST_UNEXPECTED_O) |-> $past(in_hs && IN_TLAST_I))
    else $error("unexpected end raised without last");
endmodule

bind rs_decoder_output_status rs_out_props #(.OUT_W(OUT_W),
  .STAT_W(STAT_W), .MARK_W(MARK_W)) chk_u (.CLK_SYS_I(CLK_SYS_I),
  .SRST_I(SRST_I), .IN_TVALID_I(IN_TVALID_I), .IN_TREADY_I(IN_TREADY_I),
  .IN_TLAST_I(IN_TLAST_I), .M_AXIS_OUTPUT_TVALID_O(M_AXIS_OUTPUT_TVALID_O),
  .M_AXIS_OUTPUT_TREADY_I(M_AXIS_OUTPUT_TREADY_I),
  .M_AXIS_OUTPUT_TDATA_O(M_AXIS_OUTPUT_TDATA_O),
  .M_AXIS_OUTPUT_TUSER_O(M_AXIS_OUTPUT_TUSER_O),
  .M_AXIS_OUTPUT_TLAST_O(M_AXIS_OUTPUT_TLAST_O),
  .M_AXIS_STAT_TVALID_O(M_AXIS_STAT_TVALID_O),
  .M_AXIS_STAT_TREADY_I(M_AXIS_STAT_TREADY_I),
  .M_AXIS_STAT_TDATA_O(M_AXIS_STAT_TDATA_O),
  .EVENT_TLAST_MISSING_O(EVENT_TLAST_MISSING_O),
  .EVENT_TLAST_UNEXPECTED_O(EVENT_TLAST_UNEXPECTED_O),
  .EVENT_CTRL_INVALID_O(EVENT_CTRL_INVALID_O));

// [tb/rs_out_sink.sv]
/* downstream consumer of both output channels.
   assumes one clock; stall_i makes it withhold ready part time. */
`timescale 1ns/1ps
module rs_out_sink (
  input  wire logic clk_i,
  input  wire logic stall_i,
  output logic      out_ready_o,
  output logic      stat_ready_o
);
  logic [2:0] cnt = 3'h0;
  always @(posedge clk_i) cnt <= cnt + 3'h1;
  // different counter bits (periods 4 and 8) so the two channels stall independently
  assign out_ready_o  = !stall_i || cnt[1];
  assign stat_ready_o = !stall_i || cnt[2];
endmodule

// [tb/rs_decoder_output_status_tb_top.sv]
/* self-checking bench for the decoder output block.
   assumes two channels, blocks of n=6 k=4, 40 MHz clock. */
`timescale 1ns/1ps
module rs_decoder_output_status_tb_top;
  logic clk = 0, srst = 1, sv = 0, mark = 0, ers = 0, fail = 0;
  logic ivld = 0, ilast = 0, cvld = 0, stall = 0, psel = 0, pen = 0;
  logic pwr = 0, sr, ov, ord, ol, ou, stv, strd, stl, emiss, eunex;
  logic einv, pready, pslverr;
  logic [7:0] corr = 0, raw = 0;
  logic [15:0] errcnt = 0, cn = 0, cr = 16'h2;
  logic [3:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, std, q;
  logic [23:0] od;
  logic e, ce = 1;
  logic [25:0] eq_o[$];
  logic [65:0] eq_s[$];
  int n_mismatch = 0, num_checks = 0;
  always #12.5 clk = ~clk;
  rs_decoder_output_status #(.CHANNELS(2)) dut_u (.CLK_SYS_I(clk),
    .SRST_I(srst), .CE_I(ce), .SYM_VALID_I(sv), .SYM_READY_O(sr),
    .SYM_CORR_I(corr), .SYM_RAW_I(raw), .SYM_MARK_I(mark),
    .SYM_ERASED_I(ers), .BLK_FAIL_I(fail), .BLK_ERRCNT_I(errcnt),
    .BLK_N_I(16'h6), .BLK_K_I(16'h4), .IN_TVALID_I(ivld),
    .IN_TREADY_I(1'b1), .IN_TLAST_I(ilast), .CTRL_TVALID_I(cvld),
    .CTRL_TREADY_I(1'b1), .CTRL_N_I(cn), .CTRL_R_I(cr),
    .M_AXIS_OUTPUT_TVALID_O(ov), .M_AXIS_OUTPUT_TREADY_I(ord),
    .M_AXIS_OUTPUT_TDATA_O(od), .M_AXIS_OUTPUT_TUSER_O(ou),
    .M_AXIS_OUTPUT_TLAST_O(ol), .M_AXIS_STAT_TVALID_O(stv),
    .M_AXIS_STAT_TREADY_I(strd), .M_AXIS_STAT_TDATA_O(std),
    .M_AXIS_STAT_TLAST_O(stl), .EVENT_TLAST_MISSING_O(emiss),
    .EVENT_TLAST_UNEXPECTED_O(eunex), .EVENT_CTRL_INVALID_O(einv),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr));
  rs_out_sink snk_u (.clk_i(clk), .stall_i(stall), .out_ready_o(ord),
    .stat_ready_o(strd));

  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // monitors
  // ****************************************
  always @(posedge clk) if (!srst && ov && ord) begin
    chk(eq_o.size() > 0 && {ol, ou, od} === eq_o[0], "output beat");
    if (eq_o.size() > 0) void'(eq_o.pop_front());
  end
  always @(posedge clk) if (!srst && stv && strd) begin
    chk(eq_s.size() > 0 && ((({stl, std} ^ eq_s[0][32:0]) & eq_s[0][65:33]) === 33'h0), "status word");
    if (eq_s.size() > 0) void'(eq_s.pop_front());
  end

  // ****************************************
  // bus and stream tasks
  // ****************************************
  task automatic apb(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
    @(posedge clk);
  endtask

  // d: one flipped symbol (bit0 0->1, bit2 1->0), one erasure
  task automatic blk(input logic [7:0] ch, input logic f, input logic d,
                     input logic c);
    logic [7:0] cv, rv;
    int m;
    m = c ? 6 : 4;
    eq_s.push_back({f ? 33'h1_0000_0001 : {33{1'b1}}, ch == 8'h1,
      f ? 32'h1 : (d ? {1'b0, 8'h1, 8'h1, 8'h1, 5'h2, 2'h2} : 32'h0)});
    for (int i = 0; i < 6; i++) begin
      cv = ch * 8'h10 + i[7:0];
      rv = (d && i == 1) ? cv ^ 8'h05 : cv;
      if (i < m) eq_o.push_back({ch == 8'h1 && i == m - 1, i[0], 7'h0,
        i < 4, rv, cv});
      sv <= 1'b1; corr <= cv; raw <= rv; mark <= i[0];
      ers <= d && i == 2; fail <= f; errcnt <= d ? 16'h2 : 16'h0;
      do @(posedge clk); while (sr !== 1'b1);
    end
  endtask

  task automatic drain;
    int t;
    t = 0;
    // lowered here so back-to-back blocks keep valid up between them
    sv <= 1'b0;
    while ((eq_o.size() || eq_s.size()) && t < 400) begin
      @(posedge clk);
      t++;
    end
    chk(eq_o.size() == 0 && eq_s.size() == 0, "blocks undelivered");
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_data;
    apb(1'b0, 4'h0, 32'h0);
    chk(q === 32'h0 && e === 1'b0, "mode reset value");
    blk(8'h0, 1'b0, 1'b1, 1'b0);
    blk(8'h1, 1'b1, 1'b1, 1'b0);
    blk(8'h0, 1'b0, 1'b0, 1'b0);
    blk(8'h1, 1'b0, 1'b0, 1'b0);
    drain();
  endtask

  task automatic t_check_out;
    apb(1'b1, 4'h0, 32'h1);
    stall <= 1'b1;
    blk(8'h0, 1'b0, 1'b1, 1'b1);
    blk(8'h1, 1'b0, 1'b0, 1'b1);
    blk(8'h0, 1'b0, 1'b0, 1'b1);
    blk(8'h1, 1'b0, 1'b1, 1'b1);
    drain();
    stall <= 1'b0;
  endtask

  task automatic t_events;
    cvld <= 1'b1; cn <= 16'h6;
    @(posedge clk);
    cvld <= 1'b0; ivld <= 1'b1;
    for (int j = 0; j < 12; j++) @(posedge clk);
    ilast <= 1'b1;
    @(posedge clk);
    chk(emiss === 1'b1 && eunex === 1'b0, "missing end absent");
    ilast <= 1'b0; ivld <= 1'b0;
    repeat (2) @(posedge clk);
    chk(emiss === 1'b0 && eunex === 1'b1, "unexpected end absent");
    ivld <= 1'b1;
    for (int j = 1; j < 12; j++) begin
      ilast <= j == 11;
      @(posedge clk);
    end
    ivld <= 1'b0;
    @(posedge clk);
    chk(emiss === 1'b0 && eunex === 1'b0, "event on good frame");
    apb(1'b0, 4'h4, 32'h0);
    chk(q[2:1] === 2'h3, "event flags not seen");
    apb(1'b1, 4'h4, 32'h6);
    apb(1'b0, 4'h4, 32'h0);
    chk(q[2:1] === 2'h0, "event flags not cleared");
  endtask

  task automatic t_invalid;
    cvld <= 1'b1; cn <= 16'h6; cr <= 16'h11;
    @(posedge clk);
    cvld <= 1'b0;
    repeat (20) @(posedge clk);
    chk(einv === 1'b1, "invalid control not held");
    apb(1'b0, 4'h4, 32'h0);
    chk(q[0] === 1'b1, "invalid control flag clear");
    apb(1'b0, 4'hc, 32'h0);
    chk(e === 1'b1 && q === 32'h0, "unmapped read accepted");
    ce <= 1'b0;
    @(posedge clk);
    chk(sr === 1'b0, "core not stalled while frozen");
    ce <= 1'b1;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_data();
    t_check_out();
    t_events();
    t_invalid();
    report_and_stop();
  end

  // run needs a few hundred cycles; this is a generous ceiling
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule
